// >>> rtl/llpc_ctrl.sv
// llpc_ctrl: lead/lag two-pump controller driving two relay outputs
// assumes floats and the analog sample bus are synchronous to mclk; sample_valid pulses per update
// floats still pass two register stages so that a metastable sample settles before it is decoded; chatter is not filtered
// setpoints and output modes are static configuration, best changed while both pumps are idle
// relay and pump outputs are registered; nothing reaches a pin combinationally
import llpc_pkg::*;

// Function
// - drain floats: first pump on when stop and first-start floats closed
// - drain floats: second pump also on when second-start float closed
// - drain floats: both pumps off only when all three floats open
// - fill floats: first pump on when stop and first-start floats open
// - fill floats: second pump also on when second-start float open
// - fill floats: both pumps off when all three floats closed
// - drain transducer: first pump on when level above first-start setpoint
// - drain transducer: second pump on when level above second-start setpoint
// - drain transducer: both pumps off when level below stop setpoint
// - fill transducer: first pump on when level below first-start setpoint
// - fill transducer: second pump on when level below second-start setpoint
// - fill transducer: both pumps off when level above stop setpoint
// - relay follows pump algorithm only when its mode is pump control
// - transducer level is taken from analog channel six
// - floats are read from dry contact inputs six, seven and eight
module llpc_ctrl (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [llpc_pkg::LLPC_DC_N-1:0] dry_contact,
    input wire logic [llpc_pkg::LLPC_AN_N*llpc_pkg::LLPC_AN_W-1:0] analog_in,
    input wire logic sample_valid,
    input wire llpc_pkg::llpc_dir_t direction,
    input wire llpc_pkg::llpc_src_t level_source,
    input wire logic signed [llpc_pkg::LLPC_AN_W-1:0] first_start_level,
    input wire logic signed [llpc_pkg::LLPC_AN_W-1:0] second_start_level,
    input wire logic signed [llpc_pkg::LLPC_AN_W-1:0] stop_level,
    input wire llpc_pkg::llpc_omode_t out1_mode,
    input wire llpc_pkg::llpc_omode_t out2_mode,
    input wire logic out1_manual,
    input wire logic out2_manual,
    output logic relay1,
    output logic relay2,
    output logic pump1_run,
    output logic pump2_run
);
    import llpc_pkg::*;

    // pipeline from a float edge: two synchroniser stages, the qualifier register,
    // the pump latch and finally the output register, five edges in all
    // pipeline from a transducer update: comparison register, qualifier register,
    // pump latch and output register, four edges in all counting the sample edge
    // stop beats start in every latch, so a setpoint overlap always fails safe
    // with neither start nor stop asserted the latches hold, giving the hysteresis band
    // ce low freezes every stage below; only the reset synchroniser keeps running

    // reset release
    logic [1:0] rst_sync_q;
    logic rst_n;
    // float synchroniser stages and decoded patterns
    logic [2:0] flt_meta_q;
    logic [2:0] flt_q;
    logic flt_all_closed;
    logic flt_all_open;
    logic flt_lead_closed;
    logic flt_lead_open;
    logic flt_lag_closed;
    logic flt_lag_open;
    // transducer level and sample-update marker
    logic signed [LLPC_AN_W-1:0] level;
    logic samp_d;
    logic samp_q;
    // setpoint comparison results, drain sense
    logic hi_first_d;
    logic hi_second_d;
    logic lo_stop_d;
    logic hi_first_q;
    logic hi_second_q;
    logic lo_stop_q;
    // setpoint comparison results, fill sense
    logic lo_first_d;
    logic lo_second_d;
    logic hi_stop_d;
    logic lo_first_q;
    logic lo_second_q;
    logic hi_stop_q;
    // registered start and stop qualifiers
    logic start1_d;
    logic start2_d;
    logic stop_d;
    logic start1_q;
    logic start2_q;
    logic stop_q;
    // pump latch states
    logic run1;
    logic run2;
    // output registers
    logic relay1_d;
    logic relay2_d;
    logic relay1_q;
    logic relay2_q;
    logic pump1_q;
    logic pump2_q;

    // reset release through two flip-flops
    // assertion stays asynchronous, release is aligned to mclk
    // so no stage leaves reset on a different edge than its neighbour
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= LLPC_SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // float inputs through a two-stage synchroniser; bit0 stop, bit1 first, bit2 second
    // only the second stage is read further on; the first may still be settling
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flt_meta_q <= LLPC_FLT_RST;
            flt_q <= LLPC_FLT_RST;
        end else if (ce) begin
            flt_meta_q <= {dry_contact[LLPC_FLOAT_SECOND], dry_contact[LLPC_FLOAT_FIRST],
                           dry_contact[LLPC_FLOAT_STOP]};
            flt_q <= flt_meta_q;
        end
    end

    // float patterns; a closed contact means that float has been lifted
    assign flt_lead_closed = flt_q[0] & flt_q[1];
    assign flt_lead_open = ~flt_q[0] & ~flt_q[1];
    assign flt_lag_closed = flt_q[2];
    assign flt_lag_open = ~flt_q[2];
    assign flt_all_closed = flt_q == 3'h7;
    assign flt_all_open = flt_q == 3'h0;

    // level from channel six
    assign level = analog_in[LLPC_LEVEL_CH*LLPC_AN_W +: LLPC_AN_W];

    // setpoint comparisons, refreshed only on a sample update
    // equal to a setpoint counts as neither above nor below
    // between updates the results hold, and the garbage on the bus is never compared
    always_comb begin
        hi_first_d = hi_first_q;
        hi_second_d = hi_second_q;
        lo_stop_d = lo_stop_q;
        lo_first_d = lo_first_q;
        lo_second_d = lo_second_q;
        hi_stop_d = hi_stop_q;
        samp_d = 1'b0;
        if (sample_valid) begin
            hi_first_d = level > first_start_level;
            hi_second_d = level > second_start_level;
            lo_stop_d = level < stop_level;
            lo_first_d = level < first_start_level;
            lo_second_d = level < second_start_level;
            hi_stop_d = level > stop_level;
            samp_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_first_q <= LLPC_CMP_RST;
            hi_second_q <= LLPC_CMP_RST;
            lo_stop_q <= LLPC_CMP_RST;
            lo_first_q <= LLPC_CMP_RST;
            lo_second_q <= LLPC_CMP_RST;
            hi_stop_q <= LLPC_CMP_RST;
            samp_q <= LLPC_CMP_RST;
        end else if (ce) begin
            hi_first_q <= hi_first_d;
            hi_second_q <= hi_second_d;
            lo_stop_q <= lo_stop_d;
            lo_first_q <= lo_first_d;
            lo_second_q <= lo_second_d;
            hi_stop_q <= hi_stop_d;
            samp_q <= samp_d;
        end
    end

    // start and stop qualifiers for the selected source and direction
    // the unselected source is ignored entirely, so a dead transducer
    // cannot disturb float control and chattering floats cannot disturb
    // transducer control
    always_comb begin
        start1_d = 1'b0;
        start2_d = 1'b0;
        stop_d = 1'b0;
        if (level_source == LLPC_FLOATS) begin
            // floats act on every edge; the lag pump also needs the lead pattern
            if (direction == LLPC_DRAIN) begin
                start1_d = flt_lead_closed;
                start2_d = flt_lead_closed & flt_lag_closed;
                stop_d = flt_all_open;
            end else begin
                start1_d = flt_lead_open;
                start2_d = flt_lead_open & flt_lag_open;
                stop_d = flt_all_closed;
            end
        end else if (samp_q) begin
            // transducer qualifiers last one cycle, straight after an update
            if (direction == LLPC_DRAIN) begin
                start1_d = hi_first_q;
                start2_d = hi_second_q;
                stop_d = lo_stop_q;
            end else begin
                start1_d = lo_first_q;
                start2_d = lo_second_q;
                stop_d = hi_stop_q;
            end
        end
    end

    // qualifier register breaks the path from decode into the latches
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start1_q <= 1'b0;
            start2_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (ce) begin
            start1_q <= start1_d;
            start2_q <= start2_d;
            stop_q <= stop_d;
        end
    end

    // pump latches hold between start and stop
    // both latches share one stop, so the pumps always turn off together
    // the lag latch may start on its own once the lead pattern is present
    llpc_pump_chan u_pump1 (
        .clk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .start(start1_q),
        .stop(stop_q),
        .run(run1)
    );

    llpc_pump_chan u_pump2 (
        .clk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .start(start2_q),
        .stop(stop_q),
        .run(run2)
    );

    // relay selection by output mode
    // a relay not in pump control never follows the algorithm
    // modes other than pump control and manual keep the relay released
    always_comb begin
        relay1_d = 1'b0;
        relay2_d = 1'b0;
        if (out1_mode == LLPC_OUT_PUMP) begin
            relay1_d = run1;
        end else if (out1_mode == LLPC_OUT_MANUAL) begin
            relay1_d = out1_manual;
        end
        if (out2_mode == LLPC_OUT_PUMP) begin
            relay2_d = run2;
        end else if (out2_mode == LLPC_OUT_MANUAL) begin
            relay2_d = out2_manual;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            relay1_q <= LLPC_PUMP_RST;
            relay2_q <= LLPC_PUMP_RST;
        end else if (ce) begin
            relay1_q <= relay1_d;
            relay2_q <= relay2_d;
        end
    end

    // algorithm state mirrors the latches on the same edge as the relays
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pump1_q <= LLPC_PUMP_RST;
            pump2_q <= LLPC_PUMP_RST;
        end else if (ce) begin
            pump1_q <= run1;
            pump2_q <= run2;
        end
    end

    // outputs straight from flip-flops
    assign relay1 = relay1_q;
    assign relay2 = relay2_q;
    assign pump1_run = pump1_q;
    assign pump2_run = pump2_q;
endmodule

// >>> rtl/llpc_pkg.sv
// llpc_pkg: widths, input positions and reset values for the lead/lag pump controller
// assumes a single 10 MHz system clock; shared by the controller and its pump channel
package llpc_pkg;
    localparam int LLPC_CLK_HZ = 10_000_000;
    localparam int LLPC_DC_N = 8;            // dry contact inputs
    localparam int LLPC_AN_N = 6;            // analog channels
    localparam int LLPC_AN_W = 16;           // analog sample width, signed
    localparam int LLPC_FLOAT_STOP = 5;      // dry contact six, zero based
    localparam int LLPC_FLOAT_FIRST = 6;     // dry contact seven
    localparam int LLPC_FLOAT_SECOND = 7;    // dry contact eight
    localparam int LLPC_LEVEL_CH = 5;        // analog channel six, zero based
    localparam logic LLPC_PUMP_RST = 1'b0;   // pumps off after reset
    localparam logic [1:0] LLPC_SYNC_RST = 2'b00;
    localparam logic [2:0] LLPC_FLT_RST = 3'h0;   // all floats read open after reset
    localparam logic LLPC_CMP_RST = 1'b0;         // no setpoint crossed after reset
    typedef enum logic {LLPC_DRAIN, LLPC_FILL} llpc_dir_t;
    typedef enum logic {LLPC_FLOATS, LLPC_TRANSDUCER} llpc_src_t;
    typedef enum logic [1:0] {LLPC_OUT_MANUAL, LLPC_OUT_PUMP, LLPC_OUT_OTHER} llpc_omode_t;
endpackage

// >>> rtl/llpc_pump_chan.sv
// llpc_pump_chan: one pump latch with separate start and stop conditions
// assumes start and stop are registered qualifiers in the same clock domain
module llpc_pump_chan (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic stop,
    output logic run
);
    import llpc_pkg::*;
    logic run_d;
    logic run_q;

    // stop wins, start sets, otherwise hold the previous state
    always_comb begin
        run_d = run_q;
        if (stop) begin
            run_d = 1'b0;
        end else if (start) begin
            run_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= LLPC_PUMP_RST;
        end else if (ce) begin
            run_q <= run_d;
        end
    end

    assign run = run_q;
endmodule

// >>> tb/llpc_ctrl_properties.sv
// llpc_ctrl_properties: port timing checks for the pump controller
// assumes ce held high; bound to every llpc_ctrl
module llpc_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [llpc_pkg::LLPC_DC_N-1:0] dry_contact,
    input wire llpc_pkg::llpc_dir_t direction,
    input wire llpc_pkg::llpc_src_t level_source,
    input wire llpc_pkg::llpc_omode_t out1_mode,
    input wire llpc_pkg::llpc_omode_t out2_mode,
    input wire logic out2_manual,
    input wire logic relay1,
    input wire logic relay2,
    input wire logic pump1_run,
    input wire logic pump2_run
);
    import llpc_pkg::*;
    logic [3:0] age_q, age_d;
    logic [1:0] cfg_q, cfg_d;
    logic okf;
    // cycles since reset or a direction or source change
    always_comb begin
        cfg_d = {direction, level_source};
        age_d = (cfg_d != cfg_q) ? 4'h0 : age_q + 4'(age_q != 4'hf);
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            age_q <= 4'h0;
            cfg_q <= 2'h0;
        end else begin
            age_q <= age_d;
            cfg_q <= cfg_d;
        end
    end
    assign okf = age_q > 4'h9 && level_source == LLPC_FLOATS;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    a_lead_drain: assert property (okf && direction == LLPC_DRAIN && $rose(pump1_run) |->
        $past(dry_contact[6:5], 5) == 2'h3 || $past(dry_contact[6:5], 6) == 2'h3) else $error("lead on bad");
    a_lead_fill: assert property (okf && direction == LLPC_FILL && $rose(pump1_run) |->
        $past(dry_contact[6:5], 5) == 2'h0 || $past(dry_contact[6:5], 6) == 2'h0) else $error("fill on bad");
    a_lag_drain: assert property (okf && direction == LLPC_DRAIN && $rose(pump2_run) |->
        $past(dry_contact[7:5], 5) == 3'h7 || $past(dry_contact[7:5], 6) == 3'h7) else $error("lag on bad");
    a_drain_off: assert property (okf && direction == LLPC_DRAIN && $fell(pump1_run) |->
        $past(dry_contact[7:5], 5) == 3'h0 || $past(dry_contact[7:5], 6) == 3'h0) else $error("drain off bad");
    a_fill_off: assert property (okf && direction == LLPC_FILL && $fell(pump1_run) |->
        $past(dry_contact[7:5], 5) == 3'h7 || $past(dry_contact[7:5], 6) == 3'h7) else $error("fill off bad");
    a_relay_pump: assert property ($past(out1_mode) == LLPC_OUT_PUMP |-> relay1 == pump1_run)
        else $error("relay1 not pump");
    a_relay_manual: assert property ($past(out2_mode) == LLPC_OUT_MANUAL |-> relay2 == $past(out2_manual))
        else $error("relay2 not manual");
    a_relay_off: assert property ($past(out2_mode[1]) |-> !relay2)
        else $error("relay2 not off");
endmodule
bind llpc_ctrl llpc_chk chk_u (.mclk(mclk), .reset_n(reset_n), .dry_contact(dry_contact), .direction(direction),
    .level_source(level_source), .out1_mode(out1_mode), .out2_mode(out2_mode), .out2_manual(out2_manual),
    .relay1(relay1), .relay2(relay2), .pump1_run(pump1_run), .pump2_run(pump2_run));

// >>> tb/llpc_ctrl_tb.sv
// llpc_ctrl_tb: float and level cycles through the pump controller
// assumes relays and pump states settle within 14 cycles of a change; ce dropped once
module llpc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import llpc_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, out1_manual = 1'b0, out2_manual = 1'b0, sv, relay1, relay2;
    llpc_dir_t direction = LLPC_DRAIN;
    llpc_src_t level_source = LLPC_FLOATS;
    llpc_omode_t mode = LLPC_OUT_PUMP;
    logic signed [15:0] first_lv = 16'h0064, second_lv = 16'h00c8, stop_lv = 16'h0032, level = 16'h0000;
    logic [2:0] lifted = 3'h0;
    logic [3:0] gap = 4'h0;
    logic [7:0] dc;
    logic [95:0] an;
    logic ce = 1'b1, pump1, pump2;
    logic [3:0] note;
    logic [3:0] exp_q[$];
    int miscompares = 0, checks_done = 0, cycles = 0;
    event ev;
    llpc_plant plant_u (.mclk(mclk), .lifted(lifted), .level(level), .gap(gap), .dry_contact(dc), .analog_in(an),
        .sample_valid(sv));
    llpc_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .ce(ce), .dry_contact(dc), .analog_in(an),
        .sample_valid(sv), .direction(direction), .level_source(level_source), .first_start_level(first_lv),
        .second_start_level(second_lv), .stop_level(stop_lv), .out1_mode(mode), .out2_mode(mode),
        .out1_manual(out1_manual), .out2_manual(out2_manual), .relay1(relay1), .relay2(relay2),
        .pump1_run(pump1), .pump2_run(pump2));
    always #50 mclk = ~mclk;
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [1:0] seen, input logic [1:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] %0t relays %b expected %b", $time, seen, want);
        end
    endtask
    // set sensors, let the relays settle, then note the expected pair
    // pump states equal the relays in pump control mode, else p
    task automatic go(input logic [2:0] f, input int l, input logic [1:0] e, input logic [1:0] p = 2'h3);
        lifted = f;
        level = l[15:0];
        repeat (14) @(negedge mclk);
        exp_q.push_back({e, mode == LLPC_OUT_PUMP ? e : p});
        ->ev;
    endtask
    // watcher compares relays and pump states against the oldest note
    always @(ev) begin
        note = exp_q.pop_front();
        check({relay1, relay2}, note[3:2]);
        check({pump1, pump2}, note[1:0]);
    end
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1500) begin
            miscompares++;
            results();
        end
    end
    initial begin
        void'($urandom(32'h0000_cd91));
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        go(3'h0, 0, 2'h0);
        go(3'h1, 0, 2'h0);
        go(3'h3, 0, 2'h2);
        go(3'h7, 0, 2'h3);
        ce = 1'b0;
        go(3'h0, 0, 2'h3);
        ce = 1'b1;
        go(3'h1, 0, 2'h3);
        go(3'h0, 0, 2'h0);
        direction = LLPC_FILL;
        go(3'h7, 0, 2'h0);
        go(3'h4, 0, 2'h2);
        go(3'h0, 0, 2'h3);
        go(3'h6, 0, 2'h3);
        go(3'h7, 0, 2'h0);
        direction = LLPC_DRAIN;
        level_source = LLPC_TRANSDUCER;
        go(3'h7, 20, 2'h0);
        go(3'h7, 100, 2'h0);
        go(3'h7, 101 + int'($urandom % 99), 2'h2);
        go(3'h7, 201 + int'($urandom % 999), 2'h3);
        go(3'h7, 50, 2'h3);
        go(3'h7, 49 - int'($urandom % 99), 2'h0);
        gap = 4'h6;
        direction = LLPC_FILL;
        second_lv = 16'h0032;
        stop_lv = 16'h012c;
        go(3'h0, 400, 2'h0);
        go(3'h0, 200, 2'h0);
        go(3'h0, 60 + int'($urandom % 40), 2'h2);
        go(3'h0, 49 - int'($urandom % 50), 2'h3);
        for (int m = 0; m < 4; m++) begin
            mode = llpc_omode_t'(m);
            out1_manual = 1'($urandom);
            out2_manual = ~out1_manual;
            go(3'h0, 30, m == 1 ? 2'h3 : m == 0 ? {out1_manual, out2_manual} : 2'h0, 2'h3);
        end
        mode = LLPC_OUT_PUMP;
        go(3'h0, 200, 2'h3);
        go(3'h0, 301 + int'($urandom % 500), 2'h0);
        results();
    end
endmodule

// >>> tb/llpc_plant.sv
// llpc_plant: float switches and level transducer beside the controller
// assumes the bench sets lift flags, tank level and sample gap
module llpc_plant (
    input wire logic mclk,
    input wire logic [2:0] lifted,
    input wire logic signed [llpc_pkg::LLPC_AN_W-1:0] level,
    input wire logic [3:0] gap,
    output logic [llpc_pkg::LLPC_DC_N-1:0] dry_contact = '0,
    output logic [llpc_pkg::LLPC_AN_N*llpc_pkg::LLPC_AN_W-1:0] analog_in = '0,
    output logic sample_valid = 1'b0
);
    import llpc_pkg::*;
    logic [3:0] tick = 4'h0;
    logic [llpc_pkg::LLPC_AN_N*llpc_pkg::LLPC_AN_W-1:0] mix;
    // unused contacts and channels churn; level is garbage between samples
    always @(negedge mclk) begin
        tick <= (tick >= gap) ? 4'h0 : tick + 4'h1;
        sample_valid <= tick >= gap;
        dry_contact <= {lifted, ~dry_contact[4:0]};
        mix = {$urandom, $urandom, $urandom};
        mix[LLPC_LEVEL_CH*LLPC_AN_W +: LLPC_AN_W] = (tick >= gap) ? level : ~level;
        analog_in <= mix;
    end
endmodule
